/* File: rtsc_pkg.sv */
package rtsc_pkg;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CONTROL_ADDR   = 8'h00;
  localparam logic [7:0] REG_READY_ADDR     = 8'h04;

  // Field positions in ref_temp_control
  localparam int BIT_REF_ENABLE     = 7;
  localparam int BIT_READY_FLAG     = 6;
  localparam int BIT_TEMP_ENABLE    = 5;
  localparam int BIT_TEMP_RANGE     = 4;
  localparam int BIT_CMP_GAIN_HI    = 3;
  localparam int BIT_CMP_GAIN_LO    = 2;
  localparam int BIT_CONV_GAIN_HI   = 1;
  localparam int BIT_CONV_GAIN_LO   = 0;

  // Reset value of the control register
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Gain field codes
  localparam logic [1:0] GAIN_CODE_OFF = 2'h0;
  localparam logic [1:0] GAIN_CODE_1X  = 2'h1;
  localparam logic [1:0] GAIN_CODE_2X  = 2'h2;
  localparam logic [1:0] GAIN_CODE_4X  = 2'h3;

  // Temperature sensor channel number on the converter mux
  localparam logic [2:0] TEMP_CHANNEL = 3'h5;

  // Reference settling time before ready, in ns, and derived cycle count
  localparam int CLK_PERIOD_NS   = 10;
  localparam int REF_SETTLE_NS   = 25000;
  localparam int REF_SETTLE_CYC  = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Decoded buffer gain: on flag plus one-hot x1/x2/x4 select, all clear when off
  typedef struct packed {
    logic on;
    logic x1;
    logic x2;
    logic x4;
  } rtsc_gain_t;

  // Analog control outputs grouped
  typedef struct packed {
    logic       ref_power;
    logic       temp_power;
    logic       temp_high_range;
    rtsc_gain_t cmp_gain;
    rtsc_gain_t conv_gain;
  } rtsc_analog_t;

  // Ready tracker states
  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_SETTLE = 3'b010,
    ST_READY  = 3'b100
  } rtsc_state_t;

endpackage

/* File: rtsc_ctrl.sv */
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
module rtsc_ctrl
  import rtsc_pkg::*;
#(
  parameter bit STD_VOLTAGE_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic              wb_err_o,
  // Analog side
  input  wire logic         ref_good_i,
  output rtsc_analog_t      analog_o,
  output logic              temp_channel_valid_o,
  output logic      [2:0]   temp_channel_o
);

  logic [7:0]   ctrl;
  logic [7:0]   next_ctrl;
  logic         ack;
  logic         next_ack;
  logic         err;
  logic         next_err;
  logic [31:0]  rdata;
  logic [31:0]  next_rdata;
  rtsc_state_t  state;
  rtsc_state_t  next_state;
  logic [15:0]  settle_cnt;
  logic [15:0]  next_settle_cnt;
  logic         ready_flag;
  rtsc_analog_t next_analog;
  rtsc_analog_t analog;

  // Gain field decoder shared by both buffers
  function automatic rtsc_gain_t decode_gain(input logic [1:0] code);
    rtsc_gain_t g;
    g = '0;
    unique case (code)
      GAIN_CODE_4X:  g.x4 = 1'b1;
      GAIN_CODE_2X:  g.x2 = 1'b1;
      GAIN_CODE_1X:  g.x1 = 1'b1;
      GAIN_CODE_OFF: g    = '0;
    endcase
    g.on = (code != GAIN_CODE_OFF);
    return g;
  endfunction

  // Ready flag: variant forces 1, else tracker state
  always_comb begin
    ready_flag = STD_VOLTAGE_VARIANT ? 1'b1 : (state == ST_READY);
  end

  // Bus slave; single-cycle ack, ack drops the cycle after it was given
  always_comb begin
    next_ctrl  = ctrl;
    next_ack   = 1'b0;
    next_err   = 1'b0;
    next_rdata = rdata;
    if (wb_cyc_i && wb_stb_i && !ack && !err) begin
      if (wb_adr_i == REG_CONTROL_ADDR) begin
        next_ack = 1'b1;
        if (wb_we_i && wb_sel_i[0]) begin
          // Ready bit kept out of storage so a write cannot fake it
          next_ctrl = wb_dat_i[7:0] & ~(8'h01 << BIT_READY_FLAG);
        end
        next_rdata = {24'h000000, ctrl[7], ready_flag, ctrl[5:0]};
      end else if (wb_adr_i == REG_READY_ADDR) begin
        next_ack   = 1'b1;
        next_rdata = {31'h00000000, ready_flag};
      end else begin
        next_err   = 1'b1;
        next_rdata = 32'h00000000;
      end
    end
  end

  // Reference settling tracker
  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    unique case (state)
      ST_OFF: begin
        next_settle_cnt = 16'h0000;
        if (ctrl[BIT_REF_ENABLE]) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!ctrl[BIT_REF_ENABLE]) begin
          next_state = ST_OFF;
        end else if (settle_cnt >= 16'(REF_SETTLE_CYC - 1) && ref_good_i) begin
          next_state = ST_READY;
        end else if (settle_cnt < 16'(REF_SETTLE_CYC - 1)) begin
          next_settle_cnt = settle_cnt + 16'h0001;
        end
      end
      ST_READY: begin
        if (!ctrl[BIT_REF_ENABLE] || !ref_good_i) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  // Analog controls; buffers are gated by the enable as well, since software
  // may forget to clear the gains when it turns the reference off
  always_comb begin
    next_analog                 = '0;
    next_analog.ref_power       = ctrl[BIT_REF_ENABLE];
    next_analog.temp_power      = ctrl[BIT_TEMP_ENABLE];
    next_analog.temp_high_range = ctrl[BIT_TEMP_RANGE];
    next_analog.cmp_gain  = decode_gain(ctrl[BIT_CMP_GAIN_HI:BIT_CMP_GAIN_LO]);
    next_analog.conv_gain = decode_gain(ctrl[BIT_CONV_GAIN_HI:BIT_CONV_GAIN_LO]);
    if (!ctrl[BIT_REF_ENABLE]) begin
      next_analog.cmp_gain  = '0;
      next_analog.conv_gain = '0;
    end
  end

  // Bus registers; ack and err restart low so no answer is pending after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl  <= CONTROL_RESET;
      ack   <= 1'b0;
      err   <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      ctrl  <= next_ctrl;
      ack   <= next_ack;
      err   <= next_err;
      rdata <= next_rdata;
    end
  end

  // Tracker registers; reset drops ready on the normal part until the reference settles again (the standard-voltage variant keeps it at 1)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ST_OFF;
      settle_cnt <= 16'h0000;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  // Analog control register; one cycle behind ctrl so the controls never glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog <= '0;
    end else begin
      analog <= next_analog;
    end
  end

  // Outputs
  assign wb_ack_o             = ack;
  assign wb_err_o             = err;
  assign wb_dat_o             = rdata;
  assign analog_o             = analog;
  assign temp_channel_o       = TEMP_CHANNEL;
  assign temp_channel_valid_o = analog.temp_power;

  // Assertions
  // A request is taken only while no answer stands, so one take gives one answer
  sequence s_take;
    wb_cyc_i && wb_stb_i && !ack && !err;
  endsequence

  // Write that stores the control bits
  sequence s_enable_write;
    wb_cyc_i && wb_stb_i && !ack && !err && wb_we_i && wb_sel_i[0]
      && wb_adr_i == REG_CONTROL_ADDR;
  endsequence

  // Read of the control register; its data stands with the ack one edge later
  sequence s_control_read;
    s_take ##0 (!wb_we_i && wb_adr_i == REG_CONTROL_ADDR);
  endsequence

  // Write that must leave the stored bits alone: byte lane off or other address
  sequence s_dropped_write;
    s_take ##0 (wb_we_i && (!wb_sel_i[0] || wb_adr_i != REG_CONTROL_ADDR));
  endsequence

  // Range control follows a written bit two edges later: store, then register
  sequence s_range_written;
    s_enable_write ##1 1'b1;
  endsequence

  // Comparator buffer decode
  a_cmp_gain_4x: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[BIT_REF_ENABLE] && ctrl[3:2] == GAIN_CODE_4X) |=> analog.cmp_gain.x4)
    else $error("Comparator gain 4x not decoded");

  a_cmp_gain_2x: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[BIT_REF_ENABLE] && ctrl[3:2] == GAIN_CODE_2X)
      |=> analog.cmp_gain.x2 && !analog.cmp_gain.x4 && analog.cmp_gain.on)
    else $error("Comparator gain 2x not decoded");

  a_cmp_gain_1x: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[BIT_REF_ENABLE] && ctrl[3:2] == GAIN_CODE_1X)
      |=> analog.cmp_gain.x1 && !analog.cmp_gain.x2 && analog.cmp_gain.on)
    else $error("Comparator gain 1x not decoded");

  a_cmp_gain_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[3:2] == GAIN_CODE_OFF) |=> !analog.cmp_gain.on)
    else $error("Comparator buffer not off");

  // Converter buffer decode
  a_conv_gain_map: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[BIT_REF_ENABLE] |=> analog.conv_gain.x1 == ($past(ctrl[1:0]) == GAIN_CODE_1X)
      && analog.conv_gain.x2 == ($past(ctrl[1:0]) == GAIN_CODE_2X))
    else $error("Converter gain decode wrong");

  a_conv_gain_4x: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[BIT_REF_ENABLE] && ctrl[1:0] == GAIN_CODE_4X)
      |=> analog.conv_gain.x4 && !analog.conv_gain.x1 && analog.conv_gain.on)
    else $error("Converter gain 4x not decoded");

  a_conv_gain_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[1:0] == GAIN_CODE_OFF) |=> !analog.conv_gain.on && !analog.conv_gain.x1)
    else $error("Converter buffer not off");

  // Ready flag on the standard-voltage part
  a_ready_variant: assert property (@(posedge clk_i) disable iff (rst_i)
    STD_VOLTAGE_VARIANT |-> ready_flag)
    else $error("Ready flag not forced on variant");

  // Field placement on write and on read
  a_field_layout: assert property (@(posedge clk_i) disable iff (rst_i)
    s_enable_write |=> ctrl[5:0] == $past(wb_dat_i[5:0]) && ctrl[7] == $past(wb_dat_i[7]))
    else $error("Control fields misplaced");

  a_read_layout: assert property (@(posedge clk_i) disable iff (rst_i)
    s_control_read |=> wb_dat_o == {24'h000000, $past(ctrl[BIT_REF_ENABLE]),
      $past(ready_flag), $past(ctrl[5:0])})
    else $error("Control read fields misplaced");

  // Sensor controls
  a_temp_power: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 analog.temp_power == $past(ctrl[BIT_TEMP_ENABLE]))
    else $error("Temperature power mismatch");

  a_channel_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (temp_channel_valid_o == $past(ctrl[BIT_TEMP_ENABLE]) && temp_channel_o == TEMP_CHANNEL))
    else $error("Sensor channel not routed");

  a_temp_range: assert property (@(posedge clk_i) disable iff (rst_i)
    s_range_written |=> analog.temp_high_range == $past(wb_dat_i[4], 2))
    else $error("Temperature range mismatch");

  // Ready tracking; a lost reference must show at once, not after a settle time
  a_ready_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!STD_VOLTAGE_VARIANT && !ctrl[BIT_REF_ENABLE]) |=> !ready_flag)
    else $error("Ready flag set while reference disabled");

  a_ready_settle: assert property (@(posedge clk_i) disable iff (rst_i)
    (!STD_VOLTAGE_VARIANT && $rose(state == ST_SETTLE)) |-> !ready_flag [*8])
    else $error("Ready flag set before settling");

  a_ready_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (!STD_VOLTAGE_VARIANT && $rose(ready_flag)) |-> $past(ref_good_i)
      && $past(ctrl[BIT_REF_ENABLE]) && $past(settle_cnt) == 16'(REF_SETTLE_CYC - 1))
    else $error("Ready flag rose before the reference settled");

  a_ready_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (!STD_VOLTAGE_VARIANT && ready_flag && !ref_good_i) |=> !ready_flag)
    else $error("Ready flag kept after the reference was lost");

  // Stored bits that software cannot set
  a_ready_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |-> !ctrl[BIT_READY_FLAG])
    else $error("Ready flag stored from a write");

  a_dropped_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_dropped_write |=> $stable(ctrl))
    else $error("Refused write changed the register");

  // Bus handshake
  a_take_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take |=> wb_ack_o != wb_err_o)
    else $error("Taken request without exactly one answer");

  a_bus_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    ack |=> !ack)
    else $error("Ack held for more than one cycle");

endmodule

/* File: rtsc_ctrl_bench.sv */
`timescale 1ns/1ns
// Compares two values and reports a mismatch at once
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module rtsc_ctrl_bench;
  import rtsc_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc = 1'b0, stb = 1'b0, we = 1'b0, good = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wdat = 32'h0;
  logic [3:0]   sel = 4'h0;
  logic [31:0]  rdat, rdat_std;
  logic         ack, err, tvalid;
  logic [2:0]   tchan;
  rtsc_analog_t analog;
  logic [7:0]   lfsr = 8'h05;
  logic [7:0]   r, rs, v;
  logic         e;
  int           errors = 0, num_checks = 0, cycles = 0;
  localparam int TEMP_WAIT_CYC = 20000; // 200 us at 10 ns per cycle
  logic [7:0]   corner [4] = '{8'hff, 8'hbf, 8'h3f, 8'h9a};

  // Normal part and standard-voltage part share one bus
  rtsc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .ref_good_i(good), .analog_o(analog), .temp_channel_valid_o(tvalid),
    .temp_channel_o(tchan));
  rtsc_ctrl #(.STD_VOLTAGE_VARIANT(1'b1)) dut_std (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat_std), .wb_ack_o(), .wb_err_o(), .ref_good_i(good),
    .analog_o(), .temp_channel_valid_o(), .temp_channel_o());

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Cycle ceiling cuts a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction

  // Buffers are forced off while the reference is disabled
  function automatic rtsc_gain_t exp_gain(input logic [1:0] c, input logic en);
    return '{on: en && c != 2'h0, x1: en && c == 2'h1, x2: en && c == 2'h2, x4: en && c == 2'h3};
  endfunction

  task automatic give_verdict();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Classic single cycle; request held until ack or err, only the ceiling ends a wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, 24'h0, d, s};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    r = rdat[7:0];
    rs = rdat_std[7:0];
    e = err;
    if (ack === 1'b1 && !w) `CHK(rdat[31:8], 24'h0)
    {cyc, stb, we} <= 3'b000;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 8'h00, 8'h00, 4'hf);
    `CHK(r, 8'h00)
    `CHK(rs[6], 1'b1)
    `CHK(tchan, 3'h5)
    xfer(1'b0, 8'h04, 8'h00, 4'hf);
    `CHK(r[0], 1'b0)
    `CHK(rs[0], 1'b1)
    // Corner values then random ones; ready cannot settle in this short stretch
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsr_next(lfsr);
      v = (i < 4) ? corner[i] : lfsr;
      good <= lfsr[0];
      xfer(1'b1, 8'h00, v, 4'h1);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK(analog.temp_power, v[5])
      `CHK(analog.ref_power, v[7])
      `CHK(tvalid, v[5])
      if (v[5]) `CHK(analog.temp_high_range, v[4])
      `CHK(analog.cmp_gain, exp_gain(v[3:2], v[7]))
      `CHK(analog.conv_gain, exp_gain(v[1:0], v[7]))
      xfer(1'b0, 8'h00, 8'h00, 4'hf);
      `CHK(r, v & 8'hbf)
      `CHK(rs, v | 8'h40)
    end
    // Refused writes leave the register alone
    xfer(1'b1, 8'h00, ~v, 4'he);
    xfer(1'b1, 8'h08, ~v, 4'hf);
    `CHK(e, 1'b1)
    xfer(1'b1, 8'h04, ~v, 4'hf);
    xfer(1'b0, 8'h00, 8'h00, 4'hf);
    `CHK(r, v & 8'hbf)
    // Ready only after settling with a good reference
    good <= 1'b1;
    xfer(1'b1, 8'h00, 8'h80, 4'h1);
    xfer(1'b0, 8'h04, 8'h00, 4'hf);
    `CHK(r[0], 1'b0)
    repeat (2600) @(posedge clk_i);
    xfer(1'b0, 8'h00, 8'h00, 4'hf);
    `CHK(r, 8'hc0)
    good <= 1'b0;
    repeat (3) @(posedge clk_i);
    xfer(1'b0, 8'h04, 8'h00, 4'hf);
    `CHK(r[0], 1'b0)
    good <= 1'b1;
    xfer(1'b1, 8'h00, 8'h40, 4'h1);
    xfer(1'b0, 8'h00, 8'h00, 4'hf);
    `CHK(r, 8'h00)
    // Sensor sampled as software must pace it: settle first, then a gap between samples
    xfer(1'b1, 8'h00, 8'h30, 4'h1);
    repeat (TEMP_WAIT_CYC) @(posedge clk_i);
    `CHK({tvalid, tchan, analog.temp_high_range}, {1'b1, TEMP_CHANNEL, 1'b1})
    repeat (TEMP_WAIT_CYC) @(posedge clk_i);
    `CHK({tvalid, analog.temp_power}, 2'h3)
    xfer(1'b1, 8'h00, 8'h00, 4'h1);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({tvalid, analog.temp_power, analog.temp_high_range}, 3'h0)
    give_verdict();
  end
endmodule
